// ---- rtl/bgir_defs.svh ----
// constants for the baud divider and infrared endec
`ifndef BGIR_DEFS_SVH
`define BGIR_DEFS_SVH
`define BGIR_OFS_DIV_LOW 8'h00
`define BGIR_OFS_DIV_HIGH 8'h04
`define BGIR_OFS_LINE_CTL 8'h0C
`define BGIR_OFS_INFRARED_CONTROL 8'h20
`define BGIR_OFS_STATUS 8'h24
`define BGIR_DIV_RESET 16'h0002
`define BGIR_DIV_TERM 16'h0001
`define BGIR_LCR_ACCESS_BIT 7
`define BGIR_IRC_RXEN_BIT 0
`define BGIR_IRC_LOOP_BIT 1
`define BGIR_IRC_ENC_BIT 2
`define BGIR_IRC_NP_LSB 4
`define BGIR_TICKS_PER_BIT 4'hF
`define BGIR_TX_PULSE_START 4'h7
`define BGIR_TX_PULSE_END 4'hA
`define BGIR_RX_MAX_PULSE 3'h5
`define BGIR_NP_LOW_BITS 2'h3
`endif

// ---- rtl/bgir_pkg.sv ----
// types shared by the baud divider and infrared endec
package bgir_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bgir_req_t;
   typedef struct packed {
      logic [3:0] narrow_pulse;
      logic encode_en;
      logic loop_back;
      logic rx_en;
   } bgir_irctl_t;
   typedef enum logic [1:0] {RX_IDLE, RX_LOW, RX_BIT} bgir_rxst_t;
endpackage

// ---- rtl/bgir_top.sv ----
// baud divider with infrared encoder/decoder and its register port
//
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`include "bgir_defs.svh"
module bgir_top
#(
   parameter bit HAS_IR = 1'b1
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // uart side
   input wire logic uart_txd_i,
   output logic uart_rxd_o,
   output logic baud_tick_o,
   // transceiver side
   output logic infrared_tx_out_o,
   input wire logic infrared_rx_in_i
);
   import bgir_pkg::*;

   bgir_req_t req;
   assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   // register file
   logic [7:0] div_low_reg, div_low_next, div_high_reg, div_high_next, lcr_reg, lcr_next;
   bgir_irctl_t irc_reg, irc_next;
   logic [31:0] rdata_reg, rdata_next;
   logic div_load;
   logic access_latch;
   assign access_latch = lcr_reg[`BGIR_LCR_ACCESS_BIT];

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   logic [15:0] div_word;
   assign div_word = {div_high_reg, div_low_reg};

   // decoder state, used in the status read
   bgir_rxst_t rx_st_reg, rx_st_next;
   logic rxd_reg, rxd_next;

   always_comb
   begin
      div_low_next = div_low_reg;
      div_high_next = div_high_reg;
      lcr_next = lcr_reg;
      irc_next = irc_reg;
      rdata_next = 32'h0000_0000;
      div_load = 1'b0;
      if (req.wr)
      begin
         if (hit(req.addr, `BGIR_OFS_LINE_CTL))
            lcr_next = req.wdata[7:0];
         if (access_latch && hit(req.addr, `BGIR_OFS_DIV_LOW))
         begin
            div_low_next = req.wdata[7:0];
            div_load = 1'b1;
         end
         if (access_latch && hit(req.addr, `BGIR_OFS_DIV_HIGH))
         begin
            div_high_next = req.wdata[7:0];
            div_load = 1'b1;
         end
         if (HAS_IR && hit(req.addr, `BGIR_OFS_INFRARED_CONTROL))
         begin
            irc_next.rx_en = req.wdata[`BGIR_IRC_RXEN_BIT];
            irc_next.loop_back = req.wdata[`BGIR_IRC_LOOP_BIT];
            irc_next.encode_en = req.wdata[`BGIR_IRC_ENC_BIT];
            irc_next.narrow_pulse = req.wdata[`BGIR_IRC_NP_LSB +: 4];
         end
      end
      if (req.rd)
      begin
         if (access_latch && hit(req.addr, `BGIR_OFS_DIV_LOW))
            rdata_next = {24'h00_0000, div_low_reg};
         else if (access_latch && hit(req.addr, `BGIR_OFS_DIV_HIGH))
            rdata_next = {24'h00_0000, div_high_reg};
         else if (hit(req.addr, `BGIR_OFS_LINE_CTL))
            rdata_next = {24'h00_0000, lcr_reg};
         else if (HAS_IR && hit(req.addr, `BGIR_OFS_INFRARED_CONTROL))
         begin
            rdata_next[`BGIR_IRC_RXEN_BIT] = irc_reg.rx_en;
            rdata_next[`BGIR_IRC_LOOP_BIT] = irc_reg.loop_back;
            rdata_next[`BGIR_IRC_ENC_BIT] = irc_reg.encode_en;
            rdata_next[`BGIR_IRC_NP_LSB +: 4] = irc_reg.narrow_pulse;
         end
         else if (hit(req.addr, `BGIR_OFS_STATUS))
            rdata_next = {29'h0000_0000, rxd_reg, rx_st_reg};
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         div_low_reg <= 8'(`BGIR_DIV_RESET);
         div_high_reg <= 8'h00;
         lcr_reg <= 8'h00;
         irc_reg <= '0;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         div_low_reg <= div_low_next;
         div_high_reg <= div_high_next;
         lcr_reg <= lcr_next;
         irc_reg <= irc_next;
         rdata_reg <= rdata_next;
      end
   end
   assign rdata_o = rdata_reg;

   // baud divider; divisors under two are clamped so the rate never exceeds clk/2
   logic [15:0] cnt_reg, cnt_next, load_val;
   logic tick_reg, tick_next;
   always_comb
   begin
      load_val = (div_word < `BGIR_DIV_RESET) ? `BGIR_DIV_RESET : div_word;
      if (div_load)
         load_val = ({div_high_next, div_low_next} < `BGIR_DIV_RESET) ? `BGIR_DIV_RESET
                    : {div_high_next, div_low_next};
      tick_next = 1'b0;
      cnt_next = cnt_reg - 16'h0001;
      if (div_load)
         cnt_next = load_val;
      else if (cnt_reg == `BGIR_DIV_TERM)
      begin
         cnt_next = load_val;
         tick_next = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cnt_reg <= `BGIR_DIV_RESET;
         tick_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end
   assign baud_tick_o = tick_reg;

   // encoder: tick phase within a bit, sampled uart data at bit start
   logic [3:0] tx_ph_reg, tx_ph_next;
   logic tx_bit_reg, tx_bit_next, irtx_reg, irtx_next;
   always_comb
   begin
      tx_ph_next = tx_ph_reg;
      tx_bit_next = tx_bit_reg;
      irtx_next = irtx_reg;
      if (tick_reg)
      begin
         tx_ph_next = tx_ph_reg + 4'h1;
         if (tx_ph_reg == `BGIR_TICKS_PER_BIT)
            tx_bit_next = uart_txd_i;
         irtx_next = 1'b0;
         if (HAS_IR && irc_reg.encode_en && !tx_bit_next && tx_ph_next >= `BGIR_TX_PULSE_START
             && tx_ph_next < `BGIR_TX_PULSE_END)
            irtx_next = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         tx_ph_reg <= 4'h0;
         tx_bit_reg <= 1'b1;
         irtx_reg <= 1'b0;
      end
      else
      begin
         tx_ph_reg <= tx_ph_next;
         tx_bit_reg <= tx_bit_next;
         irtx_reg <= irtx_next;
      end
   end
   assign infrared_tx_out_o = irtx_reg;

   // decoder: idle-high line, a low pulse marks a 0 bit
   logic rx_in, rx_prev_reg;
   assign rx_in = irc_reg.loop_back ? !irtx_reg : infrared_rx_in_i;
   logic [5:0] np_cnt_reg, np_cnt_next;
   logic [2:0] pw_reg, pw_next;
   logic [3:0] rx_ph_reg, rx_ph_next;
   logic pulse_ok_reg, pulse_ok_next;

   always_comb
   begin
      rx_st_next = rx_st_reg;
      rxd_next = rxd_reg;
      np_cnt_next = np_cnt_reg;
      pw_next = pw_reg;
      rx_ph_next = rx_ph_reg;
      pulse_ok_next = pulse_ok_reg;
      if (!(HAS_IR && irc_reg.rx_en))
      begin
         rx_st_next = RX_IDLE;
         rxd_next = 1'b1;
      end
      else
      begin
         unique case (rx_st_reg)
            RX_IDLE:
               if (rx_prev_reg && !rx_in)
               begin
                  rx_st_next = RX_LOW;
                  np_cnt_next = {irc_reg.narrow_pulse, `BGIR_NP_LOW_BITS};
                  pulse_ok_next = (irc_reg.narrow_pulse == 4'h0);
                  pw_next = 3'h0;
               end
            RX_LOW:
            begin
               if (np_cnt_reg != 6'h00)
                  np_cnt_next = np_cnt_reg - 6'h01;
               if (np_cnt_reg == 6'h01)
                  pulse_ok_next = 1'b1;
               if (tick_reg)
                  pw_next = pw_reg + 3'h1;
               if (pw_reg > `BGIR_RX_MAX_PULSE)
                  pulse_ok_next = 1'b0;
               if (rx_in)
               begin
                  if (pulse_ok_next && pw_reg <= `BGIR_RX_MAX_PULSE)
                  begin
                     rx_st_next = RX_BIT;
                     rxd_next = 1'b0;
                     rx_ph_next = `BGIR_TX_PULSE_START + 4'h3;
                  end
                  else
                     rx_st_next = RX_IDLE;
               end
            end
            RX_BIT:
            begin
               if (rx_prev_reg && !rx_in)
               begin
                  np_cnt_next = {irc_reg.narrow_pulse, `BGIR_NP_LOW_BITS};
                  pulse_ok_next = (irc_reg.narrow_pulse == 4'h0);
                  pw_next = 3'h0;
               end
               if (tick_reg)
               begin
                  rx_ph_next = rx_ph_reg + 4'h1;
                  if (rx_ph_reg == `BGIR_TICKS_PER_BIT)
                  begin
                     // bit ends at phase 15; the phase restarts from 10 at the end of every accepted pulse
                     rxd_next = 1'b1;
                     if (!rx_in)
                        rx_st_next = RX_LOW;
                     else
                        rx_st_next = RX_IDLE;
                  end
               end
            end
            default:
               rx_st_next = RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rx_st_reg <= RX_IDLE;
         rxd_reg <= 1'b1;
         np_cnt_reg <= 6'h00;
         pw_reg <= 3'h0;
         rx_ph_reg <= 4'h0;
         pulse_ok_reg <= 1'b0;
         rx_prev_reg <= 1'b1;
      end
      else
      begin
         rx_st_reg <= rx_st_next;
         rxd_reg <= rxd_next;
         np_cnt_reg <= np_cnt_next;
         pw_reg <= pw_next;
         rx_ph_reg <= rx_ph_next;
         pulse_ok_reg <= pulse_ok_next;
         rx_prev_reg <= rx_in;
      end
   end
   assign uart_rxd_o = rxd_reg;

   // checks
   sequence reload_s;
      cnt_reg == `BGIR_DIV_TERM && !div_load;
   endsequence
   div_count_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (cnt_reg > `BGIR_DIV_TERM && !div_load) |=> cnt_reg == $past(cnt_reg) - 16'h0001)
      else $error("divider did not decrement");
   div_reload_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      reload_s |=> tick_reg && cnt_reg >= `BGIR_DIV_RESET)
      else $error("divider reload missing");
   tick_single_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      tick_reg |=> !tick_reg)
      else $error("end-of-count longer than one cycle");
   div_min_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cnt_reg >= `BGIR_DIV_TERM)
      else $error("divider below terminal value");
   div_restart_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      div_load |=> cnt_reg == $past(load_val))
      else $error("divisor write did not restart");
   latch_guard_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (wr_i && !access_latch) |=> $stable(div_word))
      else $error("divisor changed without access latch");
   tx_one_low_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      tx_bit_reg |-> !irtx_reg)
      else $error("encoder pulse during a 1 bit");
   rx_off_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !irc_reg.rx_en |=> rxd_reg && rx_st_reg == RX_IDLE)
      else $error("decoder active while disabled");
endmodule

// ---- testbench/bgir_top_tb.sv ----
// self-checking bench for the baud divider and infrared endec
`timescale 1ns/1ns
module bgir_top_tb;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic uart_txd_i = 1'b1;
   logic echo = 1'b0;
   logic [31:0] rdata_o;
   logic uart_rxd_o;
   logic baud_tick_o;
   logic infrared_tx_out_o;
   logic infrared_rx_in_i;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int lo = 0;
   int hi_tx = 0;
   int hr = 0;
   int hi_run = 0;
   logic rxd_q = 1'b1;
   always #4 clk_i = ~clk_i;
   bgir_top u_bgir_top (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .uart_txd_i(uart_txd_i), .uart_rxd_o(uart_rxd_o),
      .baud_tick_o(baud_tick_o), .infrared_tx_out_o(infrared_tx_out_o), .infrared_rx_in_i(infrared_rx_in_i));
   // pins are wired straight to the transceiver, as if already switched to the infrared function
   bgir_xcvr u_xcvr (.clk_i(clk_i), .light_i(infrared_tx_out_o), .echo_i(echo), .rx_o(infrared_rx_in_i));
   // sampled before the edge lands, so counts never race the bench
   always @(posedge clk_i)
   begin
      cyc++;
      if (uart_rxd_o === 1'b0)
         lo++;
      if (infrared_tx_out_o === 1'b1)
         hi_tx++;
      // cycles from one falling edge of the decoded data to the next
      hr++;
      if (uart_rxd_o === 1'b0 && rxd_q === 1'b1)
      begin
         hi_run = hr;
         hr = 0;
      end
      rxd_q = uart_rxd_o;
      if (cyc == 20000)
      begin
         fail_count++;
         results();
      end
   end
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, e);
   endtask
   task automatic tk(input int n);
      repeat (n)
      begin
         @(negedge clk_i);
         while (baud_tick_o !== 1'b1)
            @(negedge clk_i);
      end
   endtask
   task automatic period(input int e);
      int n;
      n = 0;
      tk(1);
      do
      begin
         @(negedge clk_i);
         n++;
      end
      while (baud_tick_o !== 1'b1 && n < 1000);
      chk(32'(n), 32'(e));
   endtask
   // one zero bit at five clocks per tick: 7 high, 3 low, 6 high
   task automatic zb();
      u_xcvr.pulse(35, 15);
      repeat (30) @(posedge clk_i);
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   initial
   begin
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
      rd(8'h00, 32'h0);
      wr(8'h0C, 32'h80);
      rd(8'h00, 32'h2);
      rd(8'h04, 32'h0);
      period(2);
      wr(8'h00, 32'h1);
      period(2);
      wr(8'h00, 32'h5);
      rd(8'h00, 32'h5);
      period(5);
      wr(8'h04, 32'h1);
      period(261);
      wr(8'h04, 32'h0);
      wr(8'h0C, 32'h0);
      rd(8'h00, 32'h0);
      rd(8'h30, 32'h0);
      wr(8'h20, 32'h57);
      rd(8'h20, 32'h57);
      done("registers");
      wr(8'h20, 32'h04);
      @(posedge clk_i) uart_txd_i <= 1'b0;
      tk(20);
      hi_tx = 0;
      tk(32);
      chk(32'(hi_tx), 32'd30);
      @(posedge clk_i) uart_txd_i <= 1'b1;
      tk(20);
      hi_tx = 0;
      tk(32);
      chk(32'(hi_tx), 32'd0);
      done("encoder");
      wr(8'h20, 32'h01);
      lo = 0;
      zb();
      tk(20);
      chk(32'(lo != 0), 32'd1);
      // two zero bits back to back: decoded falls one bit period apart
      zb();
      zb();
      tk(20);
      chk(32'(hi_run), 32'd80);
      lo = 0;
      u_xcvr.pulse(35, 35);
      tk(40);
      chk(32'(lo), 32'd0);
      u_xcvr.pulse(35, 5);
      tk(40);
      chk(32'(lo != 0), 32'd1);
      wr(8'h20, 32'h11);
      lo = 0;
      u_xcvr.pulse(35, 6);
      tk(40);
      chk(32'(lo), 32'd0);
      u_xcvr.pulse(35, 7);
      tk(40);
      chk(32'(lo != 0), 32'd1);
      wr(8'h20, 32'h00);
      lo = 0;
      zb();
      tk(40);
      chk(32'(lo), 32'd0);
      rd(8'h24, 32'h4);
      done("decoder");
      wr(8'h20, 32'h07);
      @(posedge clk_i) uart_txd_i <= 1'b0;
      tk(40);
      chk(32'(lo != 0), 32'd1);
      @(posedge clk_i) uart_txd_i <= 1'b1;
      wr(8'h20, 32'h05);
      @(posedge clk_i) echo <= 1'b1;
      tk(40);
      lo = 0;
      @(posedge clk_i) uart_txd_i <= 1'b0;
      tk(40);
      chk(32'(lo != 0), 32'd1);
      done("loopback");
      results();
   end
endmodule

// ---- testbench/bgir_xcvr.sv ----
// infrared transceiver model facing the endec
`timescale 1ns/1ns
module bgir_xcvr
(
   // clock
   input wire logic clk_i,
   // optical side
   input wire logic light_i,
   input wire logic echo_i,
   output logic rx_o
);
   logic line_reg = 1'b1;
   // an echo shows our own light as a low pulse, idle high otherwise
   assign rx_o = echo_i ? ~light_i : line_reg;
   // sends only when the bench asks, so the link stays half duplex
   task automatic pulse(input int hi, input int lo);
      repeat (hi) @(posedge clk_i);
      line_reg <= 1'b0;
      repeat (lo) @(posedge clk_i);
      line_reg <= 1'b1;
   endtask
endmodule
